// File: hw/loop_fault_isolation_defines.svh
// Timing constants and reset values for the loop fault isolation block
`ifndef LOOP_FAULT_ISOLATION_DEFINES_SVH
`define LOOP_FAULT_ISOLATION_DEFINES_SVH

`define CLK_HZ 50000000
`define FAULT_TIMEOUT_S 7200
`define FAULT_TIMEOUT_CYC (64'(`FAULT_TIMEOUT_S) * 64'(`CLK_HZ))
`define DWELL_CYC_DEFAULT 50000000
`define LOSS_CYC_DEFAULT 150000000
`define STATUS_PERIOD_CYC_DEFAULT 50000000
`define SWITCH_CLOSED 1'b0
`define SWITCH_OPEN 1'b1

`endif

// File: hw/loop_fault_isolation_pkg.sv
// Types for the loop fault isolation block
package loop_fault_isolation_pkg;
  typedef enum logic [1:0] {
    st_normal = 2'b00,
    st_open_a = 2'b01,
    st_open_b = 2'b10,
    st_disabled = 2'b11
  } iso_state_t;
endpackage

// File: hw/loop_fault_isolation.sv
// Field node loop fault isolation: heartbeat watch, port switches, status pacing
`timescale 1ns/100ps
`include "loop_fault_isolation_defines.svh"

// Operation
// - Node sends status toward the controller while heartbeat circulates.
// - Two isolation switch outputs, one per loop port, never both open at once.
// - Losing the heartbeat starts isolation, only when isolation is enabled.
// - First step opens port A switch and listens on port B.
// - No heartbeat found: open the other port instead and listen there.
// - Alternate ports until heartbeat found or two hours since isolation start.
// - On timeout, disable isolation and close both switches.
// - Heartbeat received after timeout re-enables isolation.
// - Node next to a break keeps the facing switch open.
// - Cut-off nodes keep running locally; controller flags them offline.
// - Status sent repeatedly at a regular interval.
module loop_fault_isolation
  import loop_fault_isolation_pkg::*;
#(
  parameter logic [39:0] TIMEOUT_CYC = 40'(`FAULT_TIMEOUT_CYC),
  parameter logic [31:0] DWELL_CYC = 32'(`DWELL_CYC_DEFAULT),
  parameter logic [31:0] LOSS_CYC = 32'(`LOSS_CYC_DEFAULT),
  parameter logic [31:0] STATUS_PERIOD_CYC = 32'(`STATUS_PERIOD_CYC_DEFAULT)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic hb_seen_a,
  input wire logic hb_seen_b,
  output logic switch_open_a,
  output logic switch_open_b,
  output logic status_send,
  output logic isolating,
  output logic isolation_enabled
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Terminal count test; a limit of zero wraps, so every limit must be above zero
  function automatic logic count_done(input logic [39:0] cnt, input logic [39:0] lim);
    count_done = (cnt >= lim - 40'h1);
  endfunction

  // True in either state that holds a port switch open
  function automatic logic in_isolation(input iso_state_t st);
    in_isolation = (st == st_open_a) || (st == st_open_b);
  endfunction

  // Switch level for one port, given the state that opens it
  function automatic logic switch_level(input iso_state_t st, input iso_state_t opener);
    switch_level = (st == opener) ? `SWITCH_OPEN : `SWITCH_CLOSED;
  endfunction

  // Port swap used by the alternation
  function automatic iso_state_t other_side(input iso_state_t st);
    other_side = (st == st_open_a) ? st_open_b : st_open_a;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Detect levels come from the line receivers, outside this clock domain;
  // nothing but the second stage of each pair is read below
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic hb_a;
  logic hb_b;

  // Reset to idle low, so a dead line after reset still counts as loss
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 2'h0;
    end else if (clk_en) begin
      sync_a <= {sync_a[0], hb_seen_a};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_b <= 2'h0;
    end else if (clk_en) begin
      sync_b <= {sync_b[0], hb_seen_b};
    end
  end

  assign hb_a = sync_a[1];
  assign hb_b = sync_b[1];

  // ----------------------------------------------------------------
  // Heartbeat loss watch
  // ----------------------------------------------------------------
  iso_state_t state;
  iso_state_t next_state;
  logic [31:0] loss_cnt;
  logic hb_any;
  logic hb_lost;
  logic loss_clear;

  // Either port will do while both switches are closed
  assign hb_any = hb_a | hb_b;
  // Loss needs LOSS_CYC quiet cycles, so short line glitches are ridden out
  assign hb_lost = count_done({8'h0, loss_cnt}, {8'h0, LOSS_CYC});
  // Counted only in normal operation; isolation has its own dwell and timeout
  assign loss_clear = hb_any || (state != st_normal);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loss_cnt <= 32'h0;
    end else if (clk_en) begin
      if (loss_clear) begin
        loss_cnt <= 32'h0;
      end else if (!hb_lost) begin
        loss_cnt <= loss_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port listening
  // ----------------------------------------------------------------
  logic hb_listen;

  // An open switch leaves its own port deaf, so only the connected port counts
  always_comb begin
    unique case (state)
      st_open_a: hb_listen = hb_b;
      st_open_b: hb_listen = hb_a;
      st_normal, st_disabled: hb_listen = hb_any;
    endcase
  end

  // ----------------------------------------------------------------
  // Dwell and fault timeout
  // ----------------------------------------------------------------
  logic [31:0] dwell_cnt;
  logic [39:0] timeout_cnt;
  logic dwell_done;
  logic timed_out;
  logic dwell_clear;
  logic timeout_clear;

  assign dwell_done = count_done({8'h0, dwell_cnt}, {8'h0, DWELL_CYC});
  assign timed_out = count_done(timeout_cnt, TIMEOUT_CYC);
  // Dwell restarts on every port change and is cleared to zero while the heartbeat is heard
  assign dwell_clear = (next_state != state) || hb_listen || !in_isolation(state);
  assign timeout_clear = !in_isolation(state);

  // A dwell shorter than the heartbeat repeat time makes the node swap needlessly
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dwell_cnt <= 32'h0;
    end else if (clk_en) begin
      if (dwell_clear) begin
        dwell_cnt <= 32'h0;
      end else begin
        dwell_cnt <= dwell_cnt + 32'h1;
      end
    end
  end

  // Timeout runs from the start of isolation, not from each port change;
  // forty bits hold two hours at the default clock with room to spare
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_cnt <= 40'h0;
    end else if (clk_en) begin
      if (timeout_clear) begin
        timeout_cnt <= 40'h0;
      end else if (!timed_out) begin
        timeout_cnt <= timeout_cnt + 40'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Isolation state machine
  // ----------------------------------------------------------------
  // Sequence:
  //   normal   - both switches closed, watching both ports
  //   open_a   - port A cut off, listening on port B for one dwell
  //   open_b   - port B cut off, listening on port A for one dwell
  //   disabled - timeout spent; both closed until any heartbeat returns
  // A heartbeat on the listened port parks the node in its current state,
  // which keeps the break-facing switch open next to a wiring fault.
  // Leaving isolation therefore takes the timeout or a reset.
  // Closing both switches on timeout makes a healed loop usable at once.
  always_comb begin
    next_state = state;
    unique case (state)
      st_normal: begin
        if (hb_lost) begin
          next_state = st_open_a;
        end
      end
      st_open_a, st_open_b: begin
        if (hb_listen) begin
          next_state = state;
        end else if (timed_out) begin
          next_state = st_disabled;
        end else if (dwell_done) begin
          next_state = other_side(state);
        end
      end
      st_disabled: begin
        if (hb_any) begin
          next_state = st_normal;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_normal;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic next_switch_open_a;
  logic next_switch_open_b;
  logic next_isolating;
  logic next_isolation_enabled;

  // Taken from next_state so the pins move on the same edge as the state
  assign next_switch_open_a = switch_level(next_state, st_open_a);
  assign next_switch_open_b = switch_level(next_state, st_open_b);
  assign next_isolating = in_isolation(next_state);
  assign next_isolation_enabled = (next_state != st_disabled);

  // Reset leaves both switches closed and isolation armed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_open_a <= `SWITCH_CLOSED;
    end else if (clk_en) begin
      switch_open_a <= next_switch_open_a;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_open_b <= `SWITCH_CLOSED;
    end else if (clk_en) begin
      switch_open_b <= next_switch_open_b;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      isolating <= 1'b0;
    end else if (clk_en) begin
      isolating <= next_isolating;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      isolation_enabled <= 1'b1;
    end else if (clk_en) begin
      isolation_enabled <= next_isolation_enabled;
    end
  end

  // ----------------------------------------------------------------
  // Status pacing
  // ----------------------------------------------------------------
  // Runs regardless of loop state so cut-off nodes keep working locally
  logic [31:0] status_cnt;
  logic status_due;

  assign status_due = count_done({8'h0, status_cnt}, {8'h0, STATUS_PERIOD_CYC});

  // Period counts from reset, not from loop recovery
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_cnt <= 32'h0;
    end else if (clk_en) begin
      if (status_due) begin
        status_cnt <= 32'h0;
      end else begin
        status_cnt <= status_cnt + 32'h1;
      end
    end
  end

  // One-cycle strobe to the status transmitter, never suppressed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_send <= 1'b0;
    end else if (clk_en) begin
      status_send <= status_due;
    end
  end

endmodule

// File: tb/loop_fault_isolation_props.sv
// Port checker for the loop fault isolation block
`timescale 1ns/100ps
module loop_fault_isolation_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic hb_seen_a,
  input wire logic hb_seen_b,
  input wire logic switch_open_a,
  input wire logic switch_open_b,
  input wire logic status_send,
  input wire logic isolating,
  input wire logic isolation_enabled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  iso_flag_a: assert property (isolating == (switch_open_a || switch_open_b)) else $error("iso flag");
  one_port_a: assert property (!(switch_open_a && switch_open_b)) else $error("both open");
  status_pace_a: assert property (status_send |=> !status_send [*7] ##1 status_send) else $error("pace");
  closed_off_a: assert property (!isolation_enabled |-> !isolating) else $error("open while off");
  first_open_a: assert property ($rose(isolating) |-> switch_open_a && isolation_enabled) else $error("first");
  swap_side_a: assert property ($fell(switch_open_a) |-> switch_open_b || !isolation_enabled) else $error("swap");
  dwell_hold_a: assert property ($rose(switch_open_b) |=> (switch_open_b || !isolation_enabled) [*8])
    else $error("dwell");
  re_enable_a: assert property (!isolation_enabled && hb_seen_a |-> ##[1:4] isolation_enabled) else $error("off");
endmodule
bind loop_fault_isolation loop_fault_isolation_props loop_fault_isolation_props_i (.ref_clk(ref_clk), .rst_b(rst_b),
  .clk_en(clk_en), .hb_seen_a(hb_seen_a), .hb_seen_b(hb_seen_b), .switch_open_a(switch_open_a),
  .switch_open_b(switch_open_b), .status_send(status_send), .isolating(isolating),
  .isolation_enabled(isolation_enabled));

// File: tb/loop_controller_model.sv
// Loop controller stand-in: heartbeat per port and status tally
`timescale 1ns/100ps
module loop_controller_model (
  input wire logic ref_clk,
  input wire logic run_a,
  input wire logic run_b,
  input wire logic status_send,
  output logic hb_seen_a,
  output logic hb_seen_b,
  output int heard
);
  assign hb_seen_a = run_a;
  assign hb_seen_b = run_b;
  initial heard = 0;
  always @(posedge ref_clk) if (status_send) heard++;
endmodule

// File: tb/test_loop_fault_isolation.sv
// Self-checking bench for the loop fault isolation block
`timescale 1ns/100ps
module test_loop_fault_isolation;
  logic ref_clk = 0, rst_b = 0, run_a = 1, run_b = 1;
  logic hb_seen_a, hb_seen_b, switch_open_a, switch_open_b, status_send, isolating, isolation_enabled;
  int failures = 0, tests_run = 0, n, heard;
  always #10 ref_clk = ~ref_clk;
  loop_controller_model loop_controller_model_i (.ref_clk(ref_clk), .run_a(run_a), .run_b(run_b),
    .status_send(status_send), .hb_seen_a(hb_seen_a), .hb_seen_b(hb_seen_b), .heard(heard));
  loop_fault_isolation #(.TIMEOUT_CYC(40'hc8), .DWELL_CYC(32'ha), .LOSS_CYC(32'h5), .STATUS_PERIOD_CYC(32'h8))
    loop_fault_isolation_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .hb_seen_a(hb_seen_a),
    .hb_seen_b(hb_seen_b), .switch_open_a(switch_open_a), .switch_open_b(switch_open_b),
    .status_send(status_send), .isolating(isolating), .isolation_enabled(isolation_enabled));
  task automatic check(string what, logic exp, logic got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task end_sim;
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function logic pick(int k);
    return k == 0 ? switch_open_a : k == 1 ? !isolation_enabled : k == 2 ? isolation_enabled : status_send;
  endfunction
  // Bounded wait; an expired limit ends the run
  task automatic wait_on(int k, int lim);
    for (n = 0; n < lim && pick(k) !== 1'b1; n++) @(posedge ref_clk) #2;
    if (n == lim) begin
      failures++;
      end_sim();
    end
  endtask
  task status_pacing;
    wait_on(3, 20);
    repeat (8) @(posedge ref_clk) #2;
    check("status_send", 1, status_send);
    check("status heard", 1, heard > 0);
  endtask
  task break_side;
    run_a = 0;
    run_b = 0;
    wait_on(0, 40);
    check("switch_open_b", 0, switch_open_b);
    run_b = 1;
    repeat (30) @(posedge ref_clk) #2;
    check("switch_open_a", 1, switch_open_a);
  endtask
  task lose_all;
    run_b = 0;
    wait_on(1, 400);
    repeat (20) @(posedge ref_clk) #2;
    check("switch_open_a", 0, switch_open_a);
    check("switch_open_b", 0, switch_open_b);
    run_a = 1;
    wait_on(2, 10);
    check("isolating", 0, isolating);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk) #2;
    rst_b = 1;
    check("isolation_enabled", 1, isolation_enabled);
    status_pacing();
    break_side();
    lose_all();
    end_sim();
  end
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
